// file: core/bis_pkg.sv
package bis_pkg;
    // Timebase.
    localparam int          CLK_HZ        = 100_000_000;
    localparam int          MS_PER_S      = 1000;
    localparam int          MS_CYC        = CLK_HZ / MS_PER_S;
    localparam int          HOURS_LOCK    = 200;
    localparam int          S_PER_HOUR    = 3600;
    localparam int          LOCK_SEC      = HOURS_LOCK * S_PER_HOUR;
    // Sequence times in seconds and in milliseconds.
    localparam int          PREIGN_S      = 3;
    localparam int          PILOT_STABILIZATION_S  = 5;
    localparam int          MAIN_STAB_S   = 5;
    localparam int          SHORT_S       = 3;
    localparam int          LONG_S        = 5;
    localparam int          TEST_FLAME_S  = 15;
    localparam int          RESP_SHORT_S  = 1;
    localparam int          RESP_LONG_S   = 2;
    localparam int          POST_A_S      = 2;
    localparam int          POST_B_S      = 15;
    localparam int          POST_C_S      = 30;
    localparam int          PURGE_S       = 30;
    localparam logic [15:0] PREIGN_MS     = 16'(PREIGN_S * MS_PER_S);
    localparam logic [15:0] PSTAB_MS      = 16'(PILOT_STABILIZATION_S * MS_PER_S);
    localparam logic [15:0] MSTAB_MS      = 16'(MAIN_STAB_S * MS_PER_S);
    localparam logic [15:0] SHORT_MS      = 16'(SHORT_S * MS_PER_S);
    localparam logic [15:0] LONG_MS       = 16'(LONG_S * MS_PER_S);
    localparam logic [15:0] TFLAME_MS     = 16'(TEST_FLAME_S * MS_PER_S);
    localparam logic [15:0] RESP1_MS      = 16'(RESP_SHORT_S * MS_PER_S);
    localparam logic [15:0] RESP2_MS      = 16'(RESP_LONG_S * MS_PER_S);
    localparam logic [15:0] POSTA_MS      = 16'(POST_A_S * MS_PER_S);
    localparam logic [15:0] POSTB_MS      = 16'(POST_B_S * MS_PER_S);
    localparam logic [15:0] POSTC_MS      = 16'(POST_C_S * MS_PER_S);
    localparam logic [15:0] PURGE_MS      = 16'(PURGE_S * MS_PER_S);
    // Register map (byte addresses) and fields.
    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_STATUS   = 4'h4;
    localparam logic [3:0]  ADDR_MAINSEC  = 4'h8;
    localparam int          CTRL_MOD_BIT  = 0;
    localparam int          CTRL_POST_LSB = 1;
    localparam int          CTRL_RESP_BIT = 3;
    localparam logic [3:0]  CTRL_RESET    = 4'h1;
    localparam int          ST_STATE_LSB  = 0;
    localparam int          ST_CODE_LSB   = 8;
    localparam int          ST_JMP_LSB    = 16;
    localparam int          ST_LOCKED_BIT = 19;
    // Lockout codes.
    localparam logic [7:0]  LK_NONE       = 8'h00;
    localparam logic [7:0]  LK_FLAME      = 8'h01;
    localparam logic [7:0]  LK_LOWFIRE    = 8'h02;
    localparam logic [7:0]  LK_AIRFLOW    = 8'h03;
    localparam logic [7:0]  LK_INTERLOCK  = 8'h04;
    localparam logic [7:0]  LK_BRIDGE     = 8'h05;
    localparam logic [7:0]  LK_JUMPER     = 8'h6e;

    typedef enum logic [3:0] {
        BIS_STANDBY    = 4'h0,
        BIS_PURGE_HI   = 4'h1,
        BIS_PURGE_TIME = 4'h3,
        BIS_PURGE_LO   = 4'h2,
        BIS_PREIGN     = 4'h6,
        BIS_SAFETY     = 4'h7,
        BIS_PSTAB      = 4'h5,
        BIS_MTRIAL     = 4'h4,
        BIS_MSTAB      = 4'hc,
        BIS_RUN        = 4'hd,
        BIS_POSTPURGE  = 4'hf,
        BIS_LOCKOUT    = 4'he
    } bis_state_e;
endpackage : bis_pkg

// file: core/bis_sequencer.sv
// Function
// (RULE1) Preignition: ignition three seconds at low fire
// (RULE2) First safety time: both pilots plus ignition
// (RULE3) Modulating: low-fire open in safety trips
// (RULE4) Interlock ignored from safety time onward
// (RULE5) No flame at safety end trips
// (RULE6) Pilot stabilization: ignition off, five seconds
// (RULE7) Main valve on, trial three or five
// (RULE8) Main trial flameout locks after response time
// (RULE9) Modulating: low-fire open in trial trips
// (RULE10) Main stabilization: interrupted pilot off, flame held
// (RULE11) Run: modulate until demand opens
// (RULE12) Postpurge blower for 2, 15, 30 seconds
// (RULE13) Postpurge start: main, intermittent pilot off, low
// (RULE14) Postpurge end returns to standby
// (RULE15) Test holds purge at high, low drive
// (RULE16) Test freezes timed purge at high fire
// (RULE17) Test in stabilization: freeze, 15 s flameout
// (RULE18) Test in run drives motor low
// (RULE19) Test stops at next hold point
// (RULE20) Jumpers latched at 200 hours; change locks
// (RULE21) Airflow enabled with demand bridge locks out
// (RULE22) Three jumpers: safety, trial, airflow enable
// (RULE23) Lockout drops fuel, ignition; holds until reset
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
module bis_sequencer #(
    parameter int TICK_CYC = bis_pkg::MS_CYC,  // Clock cycles per millisecond.
    parameter int LOCK_S   = bis_pkg::LOCK_SEC // Main-valve seconds before jumpers lock.
) (
    input  wire logic        mclk_i,                 // 100 MHz clock.
    input  wire logic        srst_i,                 // Power-up reset.
    input  wire logic        flame_i,                // Flame proven.
    input  wire logic        low_fire_sw_i,          // Low-fire switch closed.
    input  wire logic        high_fire_sw_i,         // High-fire switch closed.
    input  wire logic        airflow_sw_i,           // Airflow switch closed.
    input  wire logic        demand_i,               // Demand controller closed.
    input  wire logic        preign_ilk_i,           // Preignition interlock closed.
    input  wire logic        test_sw_i,              // Run/test switch in test.
    input  wire logic        bridge_i,               // Airflow input bridged to demand.
    input  wire logic        lockout_reset_i,        // Operator lockout reset.
    input  wire logic        safety_time_jumper_i,   // High when clipped.
    input  wire logic        main_trial_jumper_i,    // High when clipped.
    input  wire logic        airflow_enable_jumper_i,// High when clipped.
    input  wire logic [3:0]  addr_i,                 // Register byte address.
    input  wire logic [31:0] wdata_i,                // Write data.
    input  wire logic        we_i,                   // Write strobe.
    input  wire logic        re_i,                   // Read strobe.
    output logic      [31:0] rdata_o,                // Read data, cycle after strobe.
    output logic             ignition_o,             // Ignition transformer.
    output logic             pilot_intr_o,           // Interrupted pilot valve.
    output logic             pilot_intm_o,           // Intermittent pilot valve.
    output logic             main_valve_o,           // Main fuel valve.
    output logic             blower_o,               // Blower motor.
    output logic             motor_high_o,           // Drive firing-rate motor high.
    output logic             motor_low_o,            // Drive firing-rate motor low.
    output logic             motor_mod_o,            // Release motor to modulation.
    output logic             lockout_o,              // Locked out.
    output logic      [7:0]  lockout_code_o,         // Lockout cause.
    output logic      [3:0]  state_o                 // Sequence state.
);
    import bis_pkg::*;

    localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);
    localparam logic [9:0]  SEC_LAST  = 10'(MS_PER_S - 1);
    localparam logic [19:0] LOCK_CNT  = 20'(LOCK_S);

    bis_state_e  state_r, state_nxt;
    logic [11:0] in_s1_r, in_s2_r;
    logic        flame, low_sw, high_sw, air_sw, dem, ilk, test, bridge, lk_rst;
    logic [2:0]  jmp;
    logic [16:0] div_r;
    logic        ms_tick;
    logic [9:0]  ms_r;
    logic        sec_tick;
    logic [15:0] tmr_r;
    logic [15:0] flo_r;
    logic        hold;
    logic [15:0] flo_lim;
    logic        flo_trip;
    logic [2:0]  jmp_r;
    logic        jlocked_r;
    logic [19:0] mainsec_r;
    logic [3:0]  ctrl_r;
    logic [7:0]  code_r, code_nxt;
    logic        modulating;
    logic [15:0] s1_ms, trial_ms, post_ms;

    // Every outside level passes two flops before the sequencer sees it.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            in_s1_r <= 12'h000;
            in_s2_r <= 12'h000;
        end else begin
            in_s1_r <= {flame_i, low_fire_sw_i, high_fire_sw_i, airflow_sw_i, demand_i,
                        preign_ilk_i, test_sw_i, bridge_i, lockout_reset_i,
                        airflow_enable_jumper_i, main_trial_jumper_i, safety_time_jumper_i};
            in_s2_r <= in_s1_r;
        end
    end
    assign {flame, low_sw, high_sw, air_sw, dem, ilk, test, bridge, lk_rst, jmp} = in_s2_r;

    // Millisecond and second enables.
    always_ff @(posedge mclk_i) begin
        if (srst_i || div_r == TICK_LAST) begin
            div_r <= 17'h00000;
        end else begin
            div_r <= div_r + 17'h00001;
        end
    end
    assign ms_tick = (div_r == TICK_LAST);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ms_r <= 10'h000;
        end else if (ms_tick) begin
            ms_r <= (ms_r == SEC_LAST) ? 10'h000 : ms_r + 10'h001;
        end
    end
    assign sec_tick = ms_tick && (ms_r == SEC_LAST);

    // Jumper settings: taken at startup, frozen after enough main-valve time.
    logic cfg_taken_r;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            jmp_r       <= 3'h0;
            cfg_taken_r <= 1'b0;
            jlocked_r   <= 1'b0;
            mainsec_r   <= 20'h00000;
        end else begin
            if (!cfg_taken_r && ms_tick) begin
                jmp_r       <= jmp; // RULE20
                cfg_taken_r <= 1'b1;
            end else if (!jlocked_r && cfg_taken_r) begin
                jmp_r <= jmp;
            end
            if (main_valve_o && sec_tick && !jlocked_r) begin
                if (mainsec_r == LOCK_CNT - 20'h00001) begin
                    jlocked_r <= 1'b1; // RULE20
                end
                mainsec_r <= mainsec_r + 20'h00001;
            end
        end
    end

    // Control register written by software.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (we_i && addr_i == ADDR_CTRL) begin
            ctrl_r <= wdata_i[3:0];
        end
    end
    assign modulating = ctrl_r[CTRL_MOD_BIT];

    always_comb begin
        s1_ms    = jmp_r[0] ? SHORT_MS : LONG_MS; // RULE22
        trial_ms = jmp_r[1] ? SHORT_MS : LONG_MS; // RULE22
        case (ctrl_r[CTRL_POST_LSB +: 2])
            2'h1:    post_ms = POSTB_MS;
            2'h2:    post_ms = POSTC_MS;
            default: post_ms = POSTA_MS; // RULE12
        endcase
    end

    // Test hold points stop the sequence where it stands.
    always_comb begin
        case (state_r)
            BIS_PURGE_HI, BIS_PURGE_TIME, BIS_PURGE_LO, BIS_PSTAB: hold = test; // RULE19
            default:                                               hold = 1'b0;
        endcase
    end

    // State timer, restarted on every state change.
    always_ff @(posedge mclk_i) begin
        if (srst_i || state_nxt != state_r) begin
            tmr_r <= 16'h0000;
        end else if (ms_tick && !hold && tmr_r != 16'hffff) begin
            tmr_r <= tmr_r + 16'h0001; // RULE16 RULE17
        end
    end

    // Flame-loss timer; the limit stretches in the stabilization test hold.
    assign flo_lim = (state_r == BIS_PSTAB && test) ? TFLAME_MS : // RULE17
                     (ctrl_r[CTRL_RESP_BIT] ? RESP2_MS : RESP1_MS); // RULE8
    always_ff @(posedge mclk_i) begin
        if (srst_i || flame) begin
            flo_r <= 16'h0000;
        end else if (ms_tick && flo_r != 16'hffff) begin
            flo_r <= flo_r + 16'h0001;
        end
    end
    assign flo_trip = (flo_r >= flo_lim);

    // Sequence.
    always_comb begin
        state_nxt = state_r;
        code_nxt  = LK_NONE;
        case (state_r)
            BIS_STANDBY: begin
                if (dem && ilk) begin
                    state_nxt = BIS_PURGE_HI;
                end
            end
            BIS_PURGE_HI: begin
                if (!ilk) begin
                    code_nxt = LK_INTERLOCK;
                end else if (!test && (high_sw || !modulating)) begin // RULE15
                    state_nxt = BIS_PURGE_TIME;
                end
            end
            BIS_PURGE_TIME: begin
                if (!ilk) begin
                    code_nxt = LK_INTERLOCK;
                end else if (!test && tmr_r >= PURGE_MS) begin // RULE16
                    state_nxt = BIS_PURGE_LO;
                end
            end
            BIS_PURGE_LO: begin
                if (!ilk) begin
                    code_nxt = LK_INTERLOCK;
                end else if (!test && (low_sw || !modulating)) begin // RULE15
                    state_nxt = BIS_PREIGN;
                end
            end
            BIS_PREIGN: begin
                if (!ilk) begin
                    code_nxt = LK_INTERLOCK;
                end else if (tmr_r >= PREIGN_MS) begin // RULE1
                    state_nxt = BIS_SAFETY;
                end
            end
            BIS_SAFETY: begin
                // Interlock is no longer looked at from here on.
                if (modulating && !low_sw) begin // RULE3 RULE4
                    code_nxt = LK_LOWFIRE;
                end else if (tmr_r >= s1_ms) begin
                    if (flame) begin // RULE5
                        state_nxt = BIS_PSTAB;
                    end else begin
                        code_nxt = LK_FLAME; // RULE5
                    end
                end
            end
            BIS_PSTAB: begin
                if (flo_trip) begin // RULE17
                    code_nxt = LK_FLAME;
                end else if (tmr_r >= PSTAB_MS && flame) begin // RULE6 RULE7
                    state_nxt = BIS_MTRIAL;
                end
            end
            BIS_MTRIAL: begin
                if (modulating && !low_sw) begin // RULE9
                    code_nxt = LK_LOWFIRE;
                end else if (flo_trip) begin // RULE8
                    code_nxt = LK_FLAME;
                end else if (tmr_r >= trial_ms) begin // RULE7
                    state_nxt = BIS_MSTAB;
                end
            end
            BIS_MSTAB: begin
                if (!flame) begin // RULE10
                    code_nxt = LK_FLAME;
                end else if (tmr_r >= MSTAB_MS) begin
                    state_nxt = BIS_RUN;
                end
            end
            BIS_RUN: begin
                if (flo_trip) begin
                    code_nxt = LK_FLAME;
                end else if (!dem) begin // RULE11
                    state_nxt = BIS_POSTPURGE;
                end
            end
            BIS_POSTPURGE: begin
                if (tmr_r >= post_ms) begin // RULE14
                    state_nxt = BIS_STANDBY;
                end
            end
            BIS_LOCKOUT: begin
                if (lk_rst && code_r != LK_JUMPER) begin // RULE20 RULE23
                    state_nxt = BIS_STANDBY;
                end
            end
            default: begin
                state_nxt = BIS_LOCKOUT;
            end
        endcase
        // Faults that apply across the firing states.
        if (state_r != BIS_LOCKOUT && state_r != BIS_STANDBY && state_r != BIS_POSTPURGE
            && jmp_r[2] && !air_sw && state_r != BIS_PURGE_HI) begin
            code_nxt = LK_AIRFLOW;
        end
        if (state_r != BIS_LOCKOUT && jmp_r[2] && bridge) begin // RULE21
            code_nxt = LK_BRIDGE;
        end
        if (state_r != BIS_LOCKOUT && jlocked_r && jmp != jmp_r) begin // RULE20
            code_nxt = LK_JUMPER;
        end
        if (code_nxt != LK_NONE) begin
            state_nxt = BIS_LOCKOUT; // RULE23
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_r <= BIS_STANDBY;
            code_r  <= LK_NONE;
        end else begin
            state_r <= state_nxt;
            if (code_nxt != LK_NONE) begin
                code_r <= code_nxt;
            end else if (state_nxt == BIS_STANDBY && state_r == BIS_LOCKOUT) begin
                code_r <= LK_NONE;
            end
        end
    end

    // Outputs are registered from the next state, so a lockout drops fuel at once.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ignition_o   <= 1'b0;
            pilot_intr_o <= 1'b0;
            pilot_intm_o <= 1'b0;
            main_valve_o <= 1'b0;
            blower_o     <= 1'b0;
            motor_high_o <= 1'b0;
            motor_low_o  <= 1'b0;
            motor_mod_o  <= 1'b0;
        end else begin
            ignition_o   <= state_nxt == BIS_PREIGN || state_nxt == BIS_SAFETY; // RULE1 RULE2 RULE6
            pilot_intr_o <= state_nxt inside {BIS_SAFETY, BIS_PSTAB, BIS_MTRIAL}; // RULE2 RULE10
            pilot_intm_o <= state_nxt inside {BIS_SAFETY, BIS_PSTAB, BIS_MTRIAL,
                                              BIS_MSTAB, BIS_RUN}; // RULE2 RULE13
            main_valve_o <= state_nxt inside {BIS_MTRIAL, BIS_MSTAB, BIS_RUN}; // RULE7 RULE13
            blower_o     <= state_nxt != BIS_STANDBY && state_nxt != BIS_LOCKOUT; // RULE12
            motor_high_o <= state_nxt == BIS_PURGE_HI || state_nxt == BIS_PURGE_TIME; // RULE15
            motor_mod_o  <= state_nxt == BIS_RUN && !test; // RULE11 RULE18
            motor_low_o  <= state_nxt inside {BIS_PURGE_LO, BIS_PREIGN, BIS_SAFETY,
                                              BIS_PSTAB, BIS_MTRIAL, BIS_MSTAB,
                                              BIS_POSTPURGE}
                            || (state_nxt == BIS_RUN && test); // RULE13 RULE18
        end
    end

    assign lockout_o      = (state_r == BIS_LOCKOUT);
    assign lockout_code_o = code_r;
    assign state_o        = state_r;

    // Register read port; unmapped addresses read zero.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h00000000;
        end else if (re_i) begin
            case (addr_i)
                ADDR_CTRL:    rdata_o <= {28'h0000000, ctrl_r};
                ADDR_STATUS:  rdata_o <= {12'h000, jlocked_r, jmp_r, code_r, 4'h0, state_r};
                ADDR_MAINSEC: rdata_o <= {12'h000, mainsec_r};
                default:      rdata_o <= 32'h00000000;
            endcase
        end else begin
            rdata_o <= 32'h00000000;
        end
    end
endmodule : bis_sequencer

// file: test/bis_plant_model.sv
module bis_plant_model #(
    parameter int MOVE_CYC = 20 // Motor travel, cycles.
) (
    input  wire logic mclk_i,       // Clock.
    input  wire logic blower_i,     // Blower.
    input  wire logic fuel_i,       // Any valve open.
    input  wire logic motor_high_i, // Drive high.
    input  wire logic motor_low_i,  // Drive low.
    input  wire logic kill_i,       // Blow flame out.
    input  wire logic air_jmp_i,    // Airflow jumper.
    output logic      flame_o,      // Flame proven.
    output logic      high_sw_o,    // High fire.
    output logic      low_sw_o,     // Low fire.
    output logic      airflow_o,    // Airflow.
    output logic      bridge_o      // Bridge fitted.
);
    int pos = MOVE_CYC / 2;
    // Slow travel makes the end switches close late.
    always @(posedge mclk_i) begin
        if (motor_high_i && pos < MOVE_CYC) pos <= pos + 1;
        else if (motor_low_i && pos > 0) pos <= pos - 1;
        flame_o <= fuel_i && !kill_i;
        airflow_o <= blower_i;
    end
    assign high_sw_o = (pos == MOVE_CYC);
    assign low_sw_o = (pos == 0);
    assign bridge_o = !air_jmp_i;
endmodule : bis_plant_model

// file: test/bis_seq_properties.sv
module bis_seq_chk
    import bis_pkg::*;
(
    input wire logic       mclk_i,         // Clock.
    input wire logic       srst_i,         // Reset.
    input wire logic       test_sw_i,      // Test.
    input wire logic       ignition_o,     // Ignition.
    input wire logic       pilot_intr_o,   // Pilot.
    input wire logic       pilot_intm_o,   // Pilot.
    input wire logic       main_valve_o,   // Main.
    input wire logic       blower_o,       // Blower.
    input wire logic       motor_low_o,    // Low.
    input wire logic       motor_mod_o,    // Modulate.
    input wire logic       lockout_o,      // Locked.
    input wire logic [7:0] lockout_code_o, // Cause.
    input wire logic [3:0] state_o         // State.
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_preign;
        state_o == BIS_PREIGN |-> ignition_o && !pilot_intr_o && !pilot_intm_o && !main_valve_o;
    endproperty
    a_preign: assert property (p_preign) else $error("preignition outputs");
    property p_safety;
        state_o == BIS_SAFETY |-> ignition_o && pilot_intr_o && pilot_intm_o && !main_valve_o;
    endproperty
    a_safety: assert property (p_safety) else $error("safety outputs");
    property p_pstab;
        state_o == BIS_PSTAB |-> !ignition_o && pilot_intr_o && !main_valve_o;
    endproperty
    a_pstab: assert property (p_pstab) else $error("stabilization outputs");
    property p_trial;
        state_o == BIS_MTRIAL |-> main_valve_o && pilot_intr_o && !ignition_o;
    endproperty
    a_trial: assert property (p_trial) else $error("main trial outputs");
    property p_mstab;
        state_o == BIS_MSTAB |-> main_valve_o && !pilot_intr_o;
    endproperty
    a_mstab: assert property (p_mstab) else $error("main stabilization outputs");
    // The switch passes two flops, so allow six cycles of test.
    property p_run_test;
        (test_sw_i && state_o == BIS_RUN)[*6] |-> motor_low_o && !motor_mod_o;
    endproperty
    a_run_test: assert property (p_run_test) else $error("run test motor");
    property p_post;
        state_o == BIS_POSTPURGE |-> blower_o && motor_low_o && !main_valve_o && !pilot_intm_o;
    endproperty
    a_post: assert property (p_post) else $error("postpurge outputs");
    property p_lock;
        lockout_o |-> !ignition_o && !pilot_intr_o && !pilot_intm_o && !main_valve_o;
    endproperty
    a_lock: assert property (p_lock) else $error("lockout outputs");
    property p_jump;
        lockout_o && lockout_code_o == LK_JUMPER |=> lockout_o && lockout_code_o == LK_JUMPER;
    endproperty
    a_jump: assert property (p_jump) else $error("jumper lockout left");
endmodule : bis_seq_chk

bind bis_sequencer bis_seq_chk bis_seq_chk_inst (
    .mclk_i(mclk_i), .srst_i(srst_i), .test_sw_i(test_sw_i), .ignition_o(ignition_o),
    .pilot_intr_o(pilot_intr_o), .pilot_intm_o(pilot_intm_o), .main_valve_o(main_valve_o),
    .blower_o(blower_o), .motor_low_o(motor_low_o), .motor_mod_o(motor_mod_o),
    .lockout_o(lockout_o), .lockout_code_o(lockout_code_o), .state_o(state_o)
);

// file: test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import bis_pkg::*;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        demand = 1'b0, ilk = 1'b0, test = 1'b0, lrst = 1'b0, jmp_s = 1'b0, kill = 1'b0;
    logic        we = 1'b0, re = 1'b0, air_j = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        flame, low_sw, high_sw, air_sw, bridge, ign, p_intr, p_intm, main_v, blower;
    logic        m_high, m_low, m_mod, lockout;
    logic [31:0] rdata;
    logic [7:0]  code;
    logic [3:0]  state;
    int          failures = 0;
    int          checks = 0;
    int          n;
    always #5 mclk_i = ~mclk_i;
    bis_sequencer #(.TICK_CYC(1), .LOCK_S(3)) bis_sequencer_inst (
        .mclk_i(mclk_i), .srst_i(srst_i), .flame_i(flame), .low_fire_sw_i(low_sw),
        .high_fire_sw_i(high_sw), .airflow_sw_i(air_sw), .demand_i(demand),
        .preign_ilk_i(ilk), .test_sw_i(test), .bridge_i(bridge), .lockout_reset_i(lrst),
        .safety_time_jumper_i(jmp_s), .main_trial_jumper_i(1'b0),
        .airflow_enable_jumper_i(air_j), .addr_i(addr), .wdata_i(wdata), .we_i(we),
        .re_i(re), .rdata_o(rdata), .ignition_o(ign), .pilot_intr_o(p_intr),
        .pilot_intm_o(p_intm), .main_valve_o(main_v), .blower_o(blower),
        .motor_high_o(m_high), .motor_low_o(m_low), .motor_mod_o(m_mod),
        .lockout_o(lockout), .lockout_code_o(code), .state_o(state));
    bis_plant_model bis_plant_model_inst (
        .mclk_i(mclk_i), .blower_i(blower), .fuel_i(p_intr | p_intm | main_v),
        .motor_high_i(m_high), .motor_low_i(m_low), .kill_i(kill), .air_jmp_i(1'b0),
        .flame_o(flame), .high_sw_o(high_sw), .low_sw_o(low_sw), .airflow_o(air_sw),
        .bridge_o(bridge));
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Durations slip a few cycles in the synchronisers.
    task automatic near(input int v, input int e);
        chk(32'(v > e - 5 && v < e + 5 ? e : v), 32'(e));
    endtask : near
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
    endtask : tick
    task automatic wait_st(input logic [3:0] s, input int lim, output int c);
        c = 0;
        while (state !== s && c < lim) begin
            @(negedge mclk_i);
            c++;
        end
        if (state !== s) begin
            chk(state, s);
            end_of_test();
        end
    endtask : wait_st
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge mclk_i);
        we <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        addr <= a;
        re <= 1'b1;
        @(posedge mclk_i);
        re <= 1'b0;
        @(negedge mclk_i);
        chk(rdata, e);
    endtask : reg_rd
    task automatic t_regs();
        reg_rd(ADDR_CTRL, 32'h1);
        reg_wr(ADDR_STATUS, 32'hffff_ffff);
        reg_rd(ADDR_STATUS, 32'h0);
        reg_rd(4'hc, 32'h0);
        reg_wr(ADDR_CTRL, 32'h9);
        reg_rd(ADDR_CTRL, 32'h9);
    endtask : t_regs
    task automatic t_run();
        tick(1);
        test <= 1'b1;
        demand <= 1'b1;
        ilk <= 1'b1;
        wait_st(BIS_PURGE_HI, 100, n);
        tick(300);
        @(negedge mclk_i);
        chk(state, BIS_PURGE_HI);
        tick(1);
        test <= 1'b0;
        wait_st(BIS_PURGE_LO, 31000, n);
        wait_st(BIS_PREIGN, 200, n);
        wait_st(BIS_SAFETY, 3100, n);
        near(n, 3000);
        wait_st(BIS_PSTAB, 5100, n);
        near(n, 5000);
        tick(1000);
        test <= 1'b1;
        tick(500);
        kill <= 1'b1;
        tick(2500);
        kill <= 1'b0;
        tick(3000);
        @(negedge mclk_i);
        chk(state, BIS_PSTAB);
        tick(1);
        test <= 1'b0;
        wait_st(BIS_MTRIAL, 5100, n);
        wait_st(BIS_MSTAB, 5100, n);
        near(n, 5000);
        wait_st(BIS_RUN, 5100, n);
        near(n, 5000);
        tick(20);
        chk(m_mod, 1'b1);
        test <= 1'b1;
        tick(20);
        test <= 1'b0;
        reg_rd(ADDR_STATUS, 32'h0008_000d);
        tick(1);
        demand <= 1'b0;
        wait_st(BIS_POSTPURGE, 20, n);
        wait_st(BIS_STANDBY, 2100, n);
        near(n, 2000);
    endtask : t_run
    task automatic t_jumper();
        tick(1);
        jmp_s <= 1'b1;
        wait_st(BIS_LOCKOUT, 50, n);
        chk(code, LK_JUMPER);
        tick(1);
        lrst <= 1'b1;
        tick(3);
        lrst <= 1'b0;
        tick(10);
        @(negedge mclk_i);
        chk(lockout, 1'b1);
    endtask : t_jumper
    task automatic t_noflame();
        tick(1);
        srst_i <= 1'b1;
        tick(3);
        srst_i <= 1'b0;
        tick(2);
        kill <= 1'b1;
        demand <= 1'b1;
        wait_st(BIS_SAFETY, 35000, n);
        tick(1);
        ilk <= 1'b0;
        wait_st(BIS_LOCKOUT, 3100, n);
        near(n, 3000);
        chk(code, LK_FLAME);
        tick(1);
        lrst <= 1'b1;
        tick(3);
        lrst <= 1'b0;
        wait_st(BIS_STANDBY, 20, n);
        chk(state, BIS_STANDBY);
        tick(1);
        air_j <= 1'b1;
        wait_st(BIS_LOCKOUT, 20, n);
        chk(code, LK_BRIDGE);
    endtask : t_noflame
    initial begin
        tick(2);
        srst_i <= 1'b0;
        t_regs();
        t_run();
        t_jumper();
        t_noflame();
        end_of_test();
    end
endmodule : testbench
